// *** common/xpc_pkg.sv ***
// Shared constants and types for the crosspoint configuration host controller
package xpc_pkg;

  // Matrix shape
  localparam int NUM_OUTPUTS = 16;
  localparam int ADDR_W      = 4;
  localparam int SEL_W       = 5;
  localparam int ENTRY_W     = 6;
  localparam logic [ENTRY_W-1:0] ENTRY_RESET = 6'h00;

  // Clock and pin timing, least times rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_SETUP_NS    = 50;
  localparam int T_PULSE_NS    = 50;
  localparam int T_HOLD_NS     = 50;
  localparam int T_UPDATE_NS   = 100;
  localparam int T_RESET_NS    = 1000;
  localparam int SETUP_CYC  = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC  = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC   = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UPDATE_CYC = (T_UPDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC  = (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 8;
  localparam logic [TMR_W-1:0] SETUP_LOAD  = TMR_W'(SETUP_CYC);
  localparam logic [TMR_W-1:0] PULSE_LOAD  = TMR_W'(PULSE_CYC);
  localparam logic [TMR_W-1:0] HOLD_LOAD   = TMR_W'(HOLD_CYC);
  localparam logic [TMR_W-1:0] UPDATE_LOAD = TMR_W'(UPDATE_CYC);
  localparam logic [TMR_W-1:0] RESET_LOAD  = TMR_W'(RESET_CYC);

  // Register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_TABLE  = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_UPDATE = 4'hC;

  // Field positions
  localparam int CTRL_INIT_BIT   = 0;
  localparam int CTRL_RESET_BIT  = 1;
  localparam int CTRL_AUTO_BIT   = 2;
  localparam int TBL_ADDR_LSB    = 8;
  localparam int TBL_SEND_BIT    = 16;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_INIT_BIT   = 1;
  localparam int STAT_STAGED_BIT = 2;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b010,
    ST_HOLD   = 3'b011,
    ST_UPDATE = 3'b100,
    ST_RESET  = 3'b101
  } xpc_state_type;

endpackage

// *** hdl/xpc_step_timer.sv ***
// Phase timer: counts a loaded number of cycles and flags the last one
`timescale 1ns/1ps
`default_nettype none
module xpc_step_timer
  import xpc_pkg::*;
#(
  parameter logic [TMR_W-1:0] INIT_LOAD = 8'h01
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             start,
  input  wire logic [TMR_W-1:0] load,
  output logic                  last
);

  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;

  assign cnt_d = start ? load : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
  assign last  = (cnt_q == 8'h01);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= INIT_LOAD;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule
`default_nettype wire

// *** hdl/xpc_host.sv ***
// Host controller that programs the crosspoint matrix over its parallel pins
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Program every output once before partial changes
// - Keep update high until staging is valid
// - Select parallel and hold update high
// - Shift clock high, write strobe starts high
// - Four-bit output address selects staged entry
// - First programming stages all, then updates
module xpc_host
  import xpc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  output logic      [ADDR_W-1:0] dev_output_address,
  output logic      [SEL_W-1:0]  dev_input_select,
  output logic                   dev_output_enable,
  output logic                   dev_write_strobe_n,
  output logic                   dev_update_n,
  output logic                   dev_serial_parallel_select,
  output logic                   dev_shift_clk_n,
  output logic                   dev_reset_n
);

  xpc_state_type     state_q;
  xpc_state_type     state_d;
  logic [ADDR_W-1:0] idx_q;
  logic [ADDR_W-1:0] idx_d;
  logic [ADDR_W-1:0] sel_q;
  logic              init_mode_q;
  logic              init_done_q;
  logic              auto_q;
  logic              staged_q;
  logic [31:0]       rdata_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ENTRY_W-1:0] data_q;
  logic              wr_n_q;
  logic              upd_n_q;
  logic              rst_n_q;
  logic [ENTRY_W-1:0] tbl_q [NUM_OUTPUTS];
  logic [TMR_W-1:0]  load_d;
  logic              tmr_last;

  // Register decode
  wire busy     = (state_q != ST_IDLE);
  wire wr_ctrl  = reg_wr && (reg_addr == REG_CTRL);
  wire wr_table = reg_wr && (reg_addr == REG_TABLE);
  wire wr_upd   = reg_wr && (reg_addr == REG_UPDATE);
  wire [ADDR_W-1:0] tbl_waddr = reg_wdata[TBL_ADDR_LSB +: ADDR_W];
  wire req_init  = wr_ctrl && reg_wdata[CTRL_INIT_BIT] && !busy;
  wire req_reset = wr_ctrl && reg_wdata[CTRL_RESET_BIT] && !busy;
  // Partial writes and updates are dropped until the whole staging is defined
  wire req_send  = wr_table && reg_wdata[TBL_SEND_BIT] && !busy && init_done_q;
  wire req_upd   = wr_upd && !busy && init_done_q;
  wire last_idx  = (idx_q == ADDR_W'(NUM_OUTPUTS - 1));
  wire step_done = (state_q == ST_HOLD) && tmr_last;
  // A send writes the table in the same cycle, so its entry comes from the bus
  wire [ENTRY_W-1:0] next_entry = req_send ? reg_wdata[ENTRY_W-1:0] : tbl_q[idx_d];
  // Device reset wins over a start of the initial pass in the same write
  wire init_start = req_init && !req_reset;

  wire [31:0] ctrl_rd   = {29'h0000_0000, auto_q, 2'b00};
  wire [31:0] table_rd  = {20'h0_0000, sel_q, 2'b00, tbl_q[sel_q]};
  wire [31:0] status_rd = {29'h0000_0000, staged_q, init_done_q, busy};
  wire [31:0] rd_mux    = (reg_addr == REG_CTRL)   ? ctrl_rd   :
                          (reg_addr == REG_TABLE)  ? table_rd  :
                          (reg_addr == REG_STATUS) ? status_rd : 32'h0000_0000;

  // Sequencer
  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    unique case (state_q)
      ST_IDLE: begin
        if (req_reset) begin
          state_d = ST_RESET;
        end else if (req_init) begin
          state_d = ST_SETUP;
          idx_d   = '0;
        end else if (req_send) begin
          state_d = ST_SETUP;
          idx_d   = tbl_waddr;
        end else if (req_upd) begin
          state_d = ST_UPDATE;
        end
      end
      ST_SETUP:  if (tmr_last) state_d = ST_STROBE;
      ST_STROBE: if (tmr_last) state_d = ST_HOLD;
      ST_HOLD: begin
        if (tmr_last) begin
          if (init_mode_q && !last_idx) begin
            state_d = ST_SETUP;
            idx_d   = idx_q + 1'b1;
          end else if (init_mode_q || auto_q) begin
            state_d = ST_UPDATE;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_UPDATE: if (tmr_last) state_d = ST_IDLE;
      ST_RESET:  if (tmr_last) state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  always_comb begin
    unique case (state_d)
      ST_SETUP:  load_d = SETUP_LOAD;
      ST_STROBE: load_d = PULSE_LOAD;
      ST_HOLD:   load_d = HOLD_LOAD;
      ST_UPDATE: load_d = UPDATE_LOAD;
      ST_RESET:  load_d = RESET_LOAD;
      default:   load_d = '0;
    endcase
  end

  xpc_step_timer #(
    .INIT_LOAD (RESET_LOAD)
  ) u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   ((state_d != state_q) || (state_q == ST_HOLD && state_d == ST_SETUP)),
    .load    (load_d),
    .last    (tmr_last)
  );

  // Host-side copy of the staging table, one entry per output
  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : g_tbl
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          tbl_q[g] <= ENTRY_RESET;
        end else if (wr_table && tbl_waddr == ADDR_W'(g)) begin
          tbl_q[g] <= reg_wdata[ENTRY_W-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= ST_RESET;
      idx_q       <= '0;
      sel_q       <= '0;
      init_mode_q <= 1'b0;
      init_done_q <= 1'b0;
      auto_q      <= 1'b0;
      staged_q    <= 1'b0;
      rdata_q     <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      idx_q   <= idx_d;
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
      if (wr_table) sel_q <= tbl_waddr;
      if (wr_ctrl) auto_q <= reg_wdata[CTRL_AUTO_BIT];
      if (init_start) init_mode_q <= 1'b1;
      else if (step_done && last_idx) init_mode_q <= 1'b0;
      if (init_mode_q && step_done && last_idx) init_done_q <= 1'b1;
      // A new staged entry wins over the update that clears the flag
      if (step_done) staged_q <= 1'b1;
      else if (state_q == ST_UPDATE && tmr_last) staged_q <= 1'b0;
    end
  end

  // Pin drivers straight from flops; parallel select and shift clock are tied high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q  <= '0;
      data_q  <= ENTRY_RESET;
      wr_n_q  <= 1'b1;
      upd_n_q <= 1'b1;
      rst_n_q <= 1'b0;
    end else begin
      if (state_d == ST_SETUP) begin
        addr_q <= idx_d;
        data_q <= next_entry;
      end
      wr_n_q  <= (state_d != ST_STROBE);
      upd_n_q <= (state_d != ST_UPDATE);
      rst_n_q <= (state_d != ST_RESET);
    end
  end

  assign reg_rdata                  = rdata_q;
  assign dev_output_address         = addr_q;
  assign dev_input_select           = data_q[SEL_W-1:0];
  assign dev_output_enable          = data_q[ENTRY_W-1];
  assign dev_write_strobe_n         = wr_n_q;
  assign dev_update_n               = upd_n_q;
  assign dev_serial_parallel_select = 1'b1;
  assign dev_shift_clk_n            = 1'b1;
  assign dev_reset_n                = rst_n_q;

  // Checks
  logic [4:0] init_strobes_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      init_strobes_q <= '0;
    end else if (req_init) begin
      init_strobes_q <= '0;
    end else if (init_mode_q && state_q == ST_SETUP && state_d == ST_STROBE) begin
      init_strobes_q <= init_strobes_q + 1'b1;
    end
  end

  chk_update_needs_init: assert property (@(posedge clk) disable iff (!reset_n)
    !dev_update_n |-> init_done_q)
    else $error("update driven low before full programming");
  chk_select_parallel: assert property (@(posedge clk) disable iff (!reset_n)
    !dev_write_strobe_n |-> dev_update_n && dev_serial_parallel_select)
    else $error("strobe without parallel select and update high");
  chk_shift_clock_high: assert property (@(posedge clk) disable iff (!reset_n)
    dev_shift_clk_n)
    else $error("shift clock left low");
  chk_strobe_pulse_width: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(dev_write_strobe_n) |-> $past(dev_write_strobe_n, 2) ##0
      !dev_write_strobe_n [*2] ##1 dev_write_strobe_n)
    else $error("write strobe not high before or wrong width");
  chk_address_stable: assert property (@(posedge clk) disable iff (!reset_n)
    !dev_write_strobe_n |-> $stable(dev_output_address) && $stable(dev_input_select)
      && $stable(dev_output_enable))
    else $error("address or data moved during strobe");
  chk_init_all_staged: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(init_done_q) |-> init_strobes_q == 5'h10 && $past(dev_update_n))
    else $error("initial pass did not stage all outputs");
  chk_partial_refused: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_table && reg_wdata[TBL_SEND_BIT] && !init_done_q && !busy) |=> state_q == ST_IDLE)
    else $error("partial write accepted before full programming");
  chk_init_then_update: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(init_done_q) |-> ##[1:2] !dev_update_n)
    else $error("update did not follow initial pass");

  cov_init_done: cover property (@(posedge clk) disable iff (!reset_n) $rose(init_done_q));
  cov_single_send: cover property (@(posedge clk) disable iff (!reset_n) req_send);
  cov_device_reset: cover property (@(posedge clk) disable iff (!reset_n)
    init_done_q && $fell(dev_reset_n));

endmodule
`default_nettype wire

// *** bench/xpc_dev_model.sv ***
// Behavioural model of the crosspoint matrix configuration pins
`timescale 1ns/1ps
`default_nettype none
module xpc_dev_model #(
  parameter logic [95:0] PWR_FILL = 96'h0000_0000_0000_0000_0000_0000
) (
  input  wire logic [3:0]       output_address,
  input  wire logic [4:0]       input_select,
  input  wire logic             output_enable_bit,
  input  wire logic             write_strobe_n,
  input  wire logic             update_n,
  input  wire logic             serial_parallel_select,
  input  wire logic             shift_clk_n,
  input  wire logic             reset_n,
  output logic      [15:0][5:0] staged,
  output logic      [15:0][5:0] active,
  output logic      [7:0]       violations
);

  // First rank powers up arbitrary and no reset ever clears it
  logic [15:0][5:0] stage_q    = PWR_FILL;
  logic [15:0]      written_q  = 16'h0000;
  logic [7:0]       strobe_bad = 8'h00;
  logic [7:0]       update_bad = 8'h00;
  logic [7:0]       serial_bad = 8'h00;

  // Falling write strobe latches the addressed entry in parallel mode
  always @(negedge write_strobe_n) begin
    if (serial_parallel_select) begin
      stage_q[output_address]   <= {output_enable_bit, input_select};
      written_q[output_address] <= 1'b1;
    end
    if (!serial_parallel_select || !update_n || !shift_clk_n) begin
      strobe_bad <= strobe_bad + 8'h01;
    end
  end

  // Update before every entry was written moves arbitrary data into the matrix
  always @(negedge update_n) begin
    if (written_q != 16'hFFFF) begin
      update_bad <= update_bad + 8'h01;
    end
  end

  // No serial data pin here: a serial pass would rewrite every entry
  always @(negedge serial_parallel_select) begin
    serial_bad <= serial_bad + 8'h01;
  end

  // Second rank: cleared by reset, transparent while update is low
  always_latch begin
    if (!reset_n) begin
      active <= '0;
    end else if (!update_n) begin
      active <= stage_q;
    end
  end

  assign staged     = stage_q;
  assign violations = strobe_bad + update_bad + serial_bad;

endmodule
`default_nettype wire

// *** bench/crosspoint_parallel_config_tb_top.sv ***
// Testbench of the crosspoint host controller against the device model
`timescale 1ns/1ps
`default_nettype none
module crosspoint_parallel_config_tb_top;
  import xpc_pkg::*;
  localparam logic [95:0] FILL = 96'h1234_5678_9ABC_DEF0_0F1E_2D3C;
  logic             clk = 1'b0;
  logic             reset_n = 1'b0;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [3:0]       reg_addr = 4'h0;
  logic [31:0]      reg_wdata = 32'h0000_0000;
  logic [31:0]      rd;
  wire logic [31:0] reg_rdata;
  wire logic [3:0]  d_addr;
  wire logic [4:0]  d_sel;
  wire logic        d_en;
  wire logic        d_wr_n;
  wire logic        d_upd_n;
  wire logic        d_sp;
  wire logic        d_sck_n;
  wire logic        d_rst_n;
  logic [15:0][5:0] staged;
  logic [15:0][5:0] active;
  logic [15:0][5:0] exp_m;
  logic [7:0]       violations;
  int               err_count = 0;
  int               compares = 0;

  always #12.5 clk = ~clk;

  xpc_host uut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dev_output_address(d_addr), .dev_input_select(d_sel), .dev_output_enable(d_en),
    .dev_write_strobe_n(d_wr_n), .dev_update_n(d_upd_n),
    .dev_serial_parallel_select(d_sp), .dev_shift_clk_n(d_sck_n), .dev_reset_n(d_rst_n)
  );

  xpc_dev_model #(.PWR_FILL(FILL)) model (
    .output_address(d_addr), .input_select(d_sel), .output_enable_bit(d_en),
    .write_strobe_n(d_wr_n), .update_n(d_upd_n), .serial_parallel_select(d_sp),
    .shift_clk_n(d_sck_n), .reset_n(d_rst_n), .staged(staged), .active(active),
    .violations(violations)
  );

  task automatic tally_and_finish;
    $display("mismatches %0d of %0d compares", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_matrix(input logic [95:0] got, input logic [95:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected matrix at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  // Polls status until the controller is idle; a stuck busy counts as a mismatch
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      reg_read(REG_STATUS);
      n++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 500);
    if (n >= 500) err_count++;
  endtask

  function automatic logic [5:0] ent(input int i);
    return {(i != 7), 5'(31 - 2 * i)};
  endfunction

  initial begin
    #(25 * 20000);
    err_count++;
    tally_and_finish;
  end

  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    reg_read(REG_STATUS);
    check_word(rd, 32'h0000_0001);
    wait_idle;
    check_matrix(active, '0);
    // Update and send before the first full pass must not reach the pins
    reg_write(REG_UPDATE, 32'h0000_0000);
    reg_write(REG_TABLE, 32'h0001_0520);
    repeat (12) @(posedge clk);
    check_matrix(staged, FILL);
    check_matrix(active, '0);
    for (int i = 0; i < 16; i++) begin
      exp_m[i] = ent(i);
      reg_write(REG_TABLE, {20'h0_0000, 4'(i), 2'b00, ent(i)});
    end
    reg_read(REG_TABLE);
    check_word(rd, {20'h0_0000, 4'hF, 2'b00, ent(15)});
    reg_read(4'h2);
    check_word(rd, 32'h0000_0000);
    reg_write(REG_CTRL, 32'h0000_0001);
    repeat (60) @(posedge clk);
    check_matrix(active, '0);
    wait_idle;
    check_matrix(staged, exp_m);
    check_matrix(active, exp_m);
    check_word(rd, 32'h0000_0002);
    // One output staged without auto update: matrix keeps the old routing
    exp_m[5] = 6'h20;
    reg_write(REG_TABLE, 32'h0001_0520);
    wait_idle;
    check_matrix(staged, exp_m);
    check_word(rd, 32'h0000_0006);
    check_word({26'h000_0000, active[5]}, {26'h000_0000, ent(5)});
    reg_write(REG_UPDATE, 32'h0000_0000);
    wait_idle;
    check_matrix(active, exp_m);
    reg_write(REG_CTRL, 32'h0000_0004);
    reg_read(REG_CTRL);
    check_word(rd, 32'h0000_0004);
    exp_m[3] = 6'h00;
    reg_write(REG_TABLE, 32'h0001_0300);
    wait_idle;
    check_matrix(active, exp_m);
    check_word(rd, 32'h0000_0002);
    reg_write(REG_CTRL, 32'h0000_0002);
    wait_idle;
    check_matrix(active, '0);
    check_matrix(staged, exp_m);
    reg_write(REG_UPDATE, 32'h0000_0000);
    wait_idle;
    check_matrix(active, exp_m);
    check_word({24'h00_0000, violations}, 32'h0000_0000);
    tally_and_finish;
  end
endmodule
`default_nettype wire
